// File: pkg/orta_pkg.sv
package orta_pkg;

   localparam int NUM_ADC     = 5;
   localparam int NUM_CH      = 6;
   localparam int TEMP_CH     = 5;
   localparam int THR_WIDTH   = 12;
   localparam int HYST_WIDTH  = 5;
   localparam int NUM_PAIRS   = 2;

   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_CH_STATUS    = 8'h70;
   localparam logic [7:0] IDX_TEMP_STATUS  = 8'h71;
   localparam logic [7:0] IDX_THR_FIRST    = 8'h80;
   localparam logic [7:0] IDX_TEMP_UP_LOW  = 8'h94;
   localparam logic [7:0] IDX_TEMP_UP_HIGH = 8'h95;
   localparam logic [7:0] IDX_TEMP_LO_LOW  = 8'h96;
   localparam logic [7:0] IDX_TEMP_LO_HIGH = 8'h97;
   localparam logic [7:0] IDX_THR_LAST     = 8'h97;
   localparam logic [7:0] IDX_TEMP_HYST    = 8'hA5;

   // byte slots inside one channel's group of four
   localparam logic [1:0] SLOT_UP_LOW  = 2'h0;
   localparam logic [1:0] SLOT_UP_HIGH = 2'h1;
   localparam logic [1:0] SLOT_LO_LOW  = 2'h2;
   localparam logic [1:0] SLOT_LO_HIGH = 2'h3;

   localparam logic [7:0] CH_UP_LOW_RST    = 8'hFF;
   localparam logic [7:0] CH_UP_HIGH_RST   = 8'h0F;
   localparam logic [7:0] CH_LO_LOW_RST    = 8'h00;
   localparam logic [7:0] CH_LO_HIGH_RST   = 8'h00;
   localparam logic [7:0] TEMP_UP_LOW_RST  = 8'hFF;
   localparam logic [7:0] TEMP_UP_HIGH_RST = 8'h07;
   localparam logic [7:0] TEMP_LO_LOW_RST  = 8'h00;
   localparam logic [7:0] TEMP_LO_HIGH_RST = 8'h08;
   localparam logic [4:0] TEMP_HYST_RST    = 5'h08;
   localparam logic [7:0] HIGH_BYTE_MASK   = 8'h0F;

   localparam int TEMP_OVER_BIT  = 1;
   localparam int TEMP_UNDER_BIT = 0;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD    = 3'h2;
   localparam logic       HRESP_OKAY    = 1'b0;

   typedef struct packed {
      logic                 valid;
      logic [2:0]           channel;
      logic [THR_WIDTH-1:0] data;
   } orta_result_t;

   function automatic logic [7:0] orta_byte_reset(input int ch, input int slot);
      logic [7:0] v;
      v = 8'h00;
      if (ch == TEMP_CH) begin
         unique case (slot)
            0:       v = TEMP_UP_LOW_RST;
            1:       v = TEMP_UP_HIGH_RST;
            2:       v = TEMP_LO_LOW_RST;
            default: v = TEMP_LO_HIGH_RST;
         endcase
      end else begin
         unique case (slot)
            0:       v = CH_UP_LOW_RST;
            1:       v = CH_UP_HIGH_RST;
            2:       v = CH_LO_LOW_RST;
            default: v = CH_LO_HIGH_RST;
         endcase
      end
      return v;
   endfunction : orta_byte_reset

   function automatic logic [THR_WIDTH-1:0] orta_limit_reset(input int ch, input int pair);
      logic [7:0] lo;
      logic [7:0] hi;
      lo = orta_byte_reset(ch, 2 * pair);
      hi = orta_byte_reset(ch, 2 * pair + 1);
      return {hi[3:0], lo};
   endfunction : orta_limit_reset

endpackage : orta_pkg

// File: hdl/orta_window.sv
`timescale 1ns/1ps
module orta_window #(
   parameter bit SIGNED_CMP = 1'b0
) (
   input  wire logic [orta_pkg::THR_WIDTH-1:0] data_i,
   input  wire logic [orta_pkg::THR_WIDTH-1:0] upper_i,
   input  wire logic [orta_pkg::THR_WIDTH-1:0] lower_i,
   output logic                                outside_o
);
   import orta_pkg::*;

   function automatic logic less(input logic [THR_WIDTH-1:0] a,
                                 input logic [THR_WIDTH-1:0] b);
      if (SIGNED_CMP)
         return $signed(a) < $signed(b);
      return a < b;
   endfunction : less

   always_comb begin
      outside_o = !less(lower_i, upper_i)
                  || less(upper_i, data_i) || less(data_i, lower_i);
   end

endmodule : orta_window

// File: hdl/orta_temp_alarm.sv
`timescale 1ns/1ps
module orta_temp_alarm #(
   parameter int CODES_PER_DEGREE = 8
) (
   input  wire logic                                 clk_sys_i,
   input  wire logic                                 reset_n_i,
   input  wire logic                                 eval_i,
   input  wire logic [orta_pkg::THR_WIDTH-1:0]       data_i,
   input  wire logic [orta_pkg::THR_WIDTH-1:0]       upper_i,
   input  wire logic [orta_pkg::THR_WIDTH-1:0]       lower_i,
   input  wire logic [orta_pkg::HYST_WIDTH-1:0]      hyst_i,
   output logic                                      over_o,
   output logic                                      under_o
);
   import orta_pkg::*;

   // widened so that limit minus hysteresis cannot wrap
   logic signed [15:0] data_s;
   logic signed [15:0] up_s;
   logic signed [15:0] lo_s;
   logic signed [15:0] hyst_s;

   always_comb begin
      data_s = 16'(signed'(data_i));
      up_s   = 16'(signed'(upper_i));
      lo_s   = 16'(signed'(lower_i));
      hyst_s = 16'(signed'({1'b0, hyst_i}) * signed'(16'(CODES_PER_DEGREE)));
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         over_o <= 1'b0;
      end else if (eval_i) begin
         if (data_s > up_s)
            over_o <= 1'b1;
         else if (data_s <= up_s - hyst_s)
            over_o <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         under_o <= 1'b0;
      end else if (eval_i) begin
         if (data_s < lo_s)
            under_o <= 1'b1;
         else if (data_s >= lo_s + hyst_s)
            under_o <= 1'b0;
      end
   end

endmodule : orta_temp_alarm

// File: hdl/orta_top.sv
`timescale 1ns/1ps
module orta_top #(
   parameter int CODES_PER_DEGREE = 8
) (
   input  wire logic                  clk_sys_i,
   input  wire logic                  reset_n_i,
   input  wire logic                  hsel_i,
   input  wire logic [31:0]           haddr_i,
   input  wire logic [1:0]            htrans_i,
   input  wire logic                  hwrite_i,
   input  wire logic [2:0]            hsize_i,
   input  wire logic [31:0]           hwdata_i,
   input  wire logic                  hready_i,
   output logic      [31:0]           hrdata_o,
   output logic                       hreadyout_o,
   output logic                       hresp_o,
   input  wire orta_pkg::orta_result_t result_i,
   output logic [orta_pkg::NUM_CH-1:0] channel_range_flag_o,
   output logic                       temp_over_flag_o,
   output logic                       temp_under_flag_o
);
   import orta_pkg::*;

   typedef enum logic [3:0] {
      S_IDLE  = 4'b0001,
      S_WRITE = 4'b0010,
      S_READ  = 4'b0100,
      S_RDONE = 4'b1000
   } orta_bus_state_t;

   orta_bus_state_t       state;
   orta_bus_state_t       next_state;
   logic [7:0]            addr_idx;
   logic                  accept;
   logic                  accept_wr;
   logic                  accept_rd;

   logic [7:0]            thr_byte    [NUM_CH][4];
   logic [THR_WIDTH-1:0]  upper_limit [NUM_CH];
   logic [THR_WIDTH-1:0]  lower_limit [NUM_CH];
   logic [NUM_CH-1:0]     pend_low    [NUM_PAIRS];
   logic [NUM_CH-1:0]     pend_high   [NUM_PAIRS];
   logic [HYST_WIDTH-1:0] temp_hysteresis;
   logic [NUM_CH-1:0]     outside;
   logic [NUM_CH-1:0]     eval;

   logic                  wr_thr;
   logic                  wr_hyst;
   logic [7:0]            wr_off;
   logic [2:0]            wr_ch;
   logic [1:0]            wr_slot;
   logic                  wr_pair;
   logic [7:0]            wr_byte;
   logic [THR_WIDTH-1:0]  joined;
   logic                  rd_fire;
   logic                  rd_clear;
   logic [31:0]           next_rdata;

   function automatic logic in_thr_block(input logic [7:0] idx);
      return (idx >= IDX_THR_FIRST) && (idx <= IDX_THR_LAST);
   endfunction : in_thr_block

   // ---------------- bus slave ----------------
   always_comb begin
      accept    = hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ) && (hsize_i == HSIZE_WORD);
      accept_wr = accept && hwrite_i;
      accept_rd = accept && !hwrite_i;
   end

   always_comb begin
      next_state = state;
      unique case (state)
         S_IDLE, S_WRITE, S_RDONE: begin
            if (accept_wr)
               next_state = S_WRITE;
            else if (accept_rd)
               next_state = S_READ;
            else
               next_state = S_IDLE;
         end
         S_READ: begin
            next_state = S_RDONE;
         end
         default: begin
            next_state = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i)
         state <= S_IDLE;
      else
         state <= next_state;
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i)
         addr_idx <= 8'h00;
      else if (accept && state != S_READ)
         addr_idx <= haddr_i[9:2];
   end

   // one wait state on reads so a write just before is always visible
   always_comb begin
      hreadyout_o = (state != S_READ);
      hresp_o     = HRESP_OKAY;
   end

   // ---------------- write decode ----------------
   always_comb begin
      wr_off  = addr_idx - IDX_THR_FIRST;
      wr_ch   = wr_off[4:2];
      wr_slot = wr_off[1:0];
      wr_pair = wr_slot[1];
      wr_byte = hwdata_i[7:0];
      wr_thr  = (state == S_WRITE) && in_thr_block(addr_idx);
      wr_hyst = (state == S_WRITE) && (addr_idx == IDX_TEMP_HYST);
      if (wr_slot[0])
         joined = {wr_byte[3:0], thr_byte[wr_ch][wr_slot ^ 2'h1]};
      else
         joined = {thr_byte[wr_ch][wr_slot ^ 2'h1][3:0], wr_byte};
   end

   // byte images as software sees them; reserved high nibbles stay zero
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         for (int ch = 0; ch < NUM_CH; ch++) begin
            for (int s = 0; s < 4; s++) begin
               thr_byte[ch][s] <= orta_byte_reset(ch, s);
            end
         end
      end else if (wr_thr) begin
         if (wr_slot[0])
            thr_byte[wr_ch][wr_slot] <= wr_byte & HIGH_BYTE_MASK;
         else
            thr_byte[wr_ch][wr_slot] <= wr_byte;
      end
   end

   // a limit is only replaced when its second byte lands, either order
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         for (int p = 0; p < NUM_PAIRS; p++) begin
            pend_low[p]  <= '0;
            pend_high[p] <= '0;
         end
      end else if (wr_thr) begin
         if (wr_slot[0]) begin
            if (pend_low[wr_pair][wr_ch])
               pend_low[wr_pair][wr_ch] <= 1'b0;
            else
               pend_high[wr_pair][wr_ch] <= 1'b1;
         end else begin
            if (pend_high[wr_pair][wr_ch])
               pend_high[wr_pair][wr_ch] <= 1'b0;
            else
               pend_low[wr_pair][wr_ch] <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         for (int ch = 0; ch < NUM_CH; ch++) begin
            upper_limit[ch] <= orta_limit_reset(ch, 0);
            lower_limit[ch] <= orta_limit_reset(ch, 1);
         end
      end else if (wr_thr) begin
         if (wr_slot[0] ? pend_low[wr_pair][wr_ch] : pend_high[wr_pair][wr_ch]) begin
            if (wr_pair)
               lower_limit[wr_ch] <= joined;
            else
               upper_limit[wr_ch] <= joined;
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i)
         temp_hysteresis <= TEMP_HYST_RST;
      else if (wr_hyst)
         temp_hysteresis <= hwdata_i[HYST_WIDTH-1:0];
   end

   // ---------------- comparison ----------------
   always_comb begin
      for (int ch = 0; ch < NUM_CH; ch++) begin
         eval[ch] = result_i.valid && (result_i.channel == 3'(ch));
      end
   end

   for (genvar g = 0; g < NUM_CH; g++) begin : g_win
      orta_window #(
         .SIGNED_CMP (g == TEMP_CH)
      ) u_win (
         .data_i    (result_i.data),
         .upper_i   (upper_limit[g]),
         .lower_i   (lower_limit[g]),
         .outside_o (outside[g])
      );
   end

   orta_temp_alarm #(
      .CODES_PER_DEGREE (CODES_PER_DEGREE)
   ) u_temp (
      .clk_sys_i (clk_sys_i),
      .reset_n_i (reset_n_i),
      .eval_i    (eval[TEMP_CH]),
      .data_i    (result_i.data),
      .upper_i   (upper_limit[TEMP_CH]),
      .lower_i   (lower_limit[TEMP_CH]),
      .hyst_i    (temp_hysteresis),
      .over_o    (temp_over_flag_o),
      .under_o   (temp_under_flag_o)
   );

   // ---------------- status and read back ----------------
   always_comb begin
      rd_fire  = (state == S_READ);
      rd_clear = rd_fire && (addr_idx == IDX_CH_STATUS);
   end

   // sticky until software reads; a new alarm in the clearing cycle survives
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         channel_range_flag_o <= '0;
      end else begin
         for (int ch = 0; ch < NUM_CH; ch++) begin
            if (eval[ch] && outside[ch])
               channel_range_flag_o[ch] <= 1'b1;
            else if (rd_clear)
               channel_range_flag_o[ch] <= 1'b0;
         end
      end
   end

   always_comb begin
      next_rdata = 32'h0000_0000;
      if (addr_idx == IDX_CH_STATUS) begin
         next_rdata[NUM_CH-1:0] = channel_range_flag_o;
      end else if (addr_idx == IDX_TEMP_STATUS) begin
         next_rdata[TEMP_OVER_BIT]  = temp_over_flag_o;
         next_rdata[TEMP_UNDER_BIT] = temp_under_flag_o;
      end else if (addr_idx == IDX_TEMP_HYST) begin
         next_rdata[HYST_WIDTH-1:0] = temp_hysteresis;
      end else if (in_thr_block(addr_idx)) begin
         next_rdata[7:0] = thr_byte[wr_ch][wr_slot];
      end
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i)
         hrdata_o <= 32'h0000_0000;
      else if (rd_fire)
         hrdata_o <= next_rdata;
   end

endmodule : orta_top

// File: verif/orta_top_monitor.sv
`timescale 1ns/1ps
module orta_top_monitor #(
   parameter int CODES_PER_DEGREE = 8
) (
   input  wire logic                   clk_sys_i,
   input  wire logic                   reset_n_i,
   input  wire logic                   hsel_i,
   input  wire logic [31:0]            haddr_i,
   input  wire logic [1:0]             htrans_i,
   input  wire logic                   hwrite_i,
   input  wire logic [2:0]             hsize_i,
   input  wire logic [31:0]            hwdata_i,
   input  wire logic                   hready_i,
   input  wire logic [31:0]            hrdata_o,
   input  wire logic                   hreadyout_o,
   input  wire logic                   hresp_o,
   input  wire orta_pkg::orta_result_t result_i,
   input  wire logic [orta_pkg::NUM_CH-1:0] channel_range_flag_o,
   input  wire logic                   temp_over_flag_o,
   input  wire logic                   temp_under_flag_o
);
   import orta_pkg::*;
   logic       take;
   logic [1:0] clr_cnt;
   assign take = hsel_i && hready_i && htrans_i == HTRANS_NONSEQ && hsize_i == HSIZE_WORD;
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!reset_n_i);
   // window of a few cycles in which a status read may clear flags
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         clr_cnt <= 2'h0;
      end else if (take && !hwrite_i && haddr_i[9:2] == IDX_CH_STATUS) begin
         clr_cnt <= 2'h3;
      end else if (clr_cnt != 2'h0) begin
         clr_cnt <= clr_cnt - 2'h1;
      end
   end
   AST_RESP_OKAY: assert property (hresp_o == HRESP_OKAY)
      else $error("response not okay");
   AST_WRITE_NOWAIT: assert property (take && hwrite_i |=> hreadyout_o)
      else $error("write stalled");
   AST_READ_WAIT: assert property (take && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
      else $error("read wait state wrong");
   AST_READY_IDLE: assert property (!hreadyout_o |-> $past(take && !hwrite_i))
      else $error("stall without read");
   AST_HRDATA_UPPER: assert property (hrdata_o[31:8] == 24'h0)
      else $error("read data upper bits set");
   AST_RDATA_STABLE: assert property ($changed(hrdata_o) |-> $past(take && !hwrite_i, 2))
      else $error("read data changed without read");
   AST_CH_RISE: assert property (|(channel_range_flag_o & ~$past(channel_range_flag_o)) |->
      $past(result_i.valid) && (channel_range_flag_o & ~$past(channel_range_flag_o)
      & ~(6'h01 << $past(result_i.channel))) == 6'h00)
      else $error("channel flag rose without its result");
   AST_CH_STICKY: assert property (|(~channel_range_flag_o & $past(channel_range_flag_o))
      |-> clr_cnt != 2'h0)
      else $error("channel flag fell without status read");
   AST_TEMP_EVAL: assert property ($changed(temp_over_flag_o) || $changed(temp_under_flag_o)
      |-> $past(result_i.valid) && $past(result_i.channel) == TEMP_CH)
      else $error("temperature flag moved without temperature result");
endmodule : orta_top_monitor

bind orta_top orta_top_monitor #(.CODES_PER_DEGREE(CODES_PER_DEGREE)) mon_u (
   .clk_sys_i, .reset_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i,
   .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .result_i, .channel_range_flag_o,
   .temp_over_flag_o, .temp_under_flag_o);

// File: verif/tb.sv
`timescale 1ns/1ps
module tb;
   import orta_pkg::*;
   logic               clk_sys_i  = 1'b0;
   logic               reset_n_i  = 1'b0;
   logic               hsel_i     = 1'b0;
   logic [31:0]        haddr_i    = 32'h0;
   logic [1:0]         htrans_i   = 2'h0;
   logic               hwrite_i   = 1'b0;
   logic [31:0]        hwdata_i   = 32'h0;
   logic [31:0]        hrdata_o;
   logic               hreadyout_o;
   logic               hresp_o;
   orta_result_t       result_i   = '0;
   logic [NUM_CH-1:0]  channel_range_flag_o;
   logic               temp_over_flag_o;
   logic               temp_under_flag_o;
   int                 n_mismatch = 0;
   int                 compares   = 0;
   logic [31:0]        rd;
   logic [7:0]         ch_rst [4] = '{8'hFF, 8'h0F, 8'h00, 8'h00};
   logic [7:0]         tp_rst [4] = '{8'hFF, 8'h07, 8'h00, 8'h08};

   orta_top #(.CODES_PER_DEGREE(8)) dut_u (
      .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
      .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(HSIZE_WORD), .hwdata_i(hwdata_i),
      .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
      .hresp_o(hresp_o), .result_i(result_i), .channel_range_flag_o(channel_range_flag_o),
      .temp_over_flag_o(temp_over_flag_o), .temp_under_flag_o(temp_under_flag_o));

   initial begin
      forever #25 clk_sys_i = ~clk_sys_i;
   end

   task automatic results();
      $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : results

   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
         n_mismatch++;
      end
   endtask : chk_reg

   task automatic chk_flag(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         $display("[ERR] t=%0t flags got=%h exp=%h", $time, got, exp);
         n_mismatch++;
      end
   endtask : chk_flag

   // holds each phase until hready is seen high; the data phase is entered once only
   task automatic bus(input logic wr_en, input logic [7:0] idx, input logic [7:0] wd);
      int n;
      n = 0;
      hsel_i   <= 1'b1;
      haddr_i  <= {22'h0, idx, 2'h0};
      htrans_i <= HTRANS_NONSEQ;
      hwrite_i <= wr_en;
      for (int p = 0; p < 2; p++) begin
         do begin
            @(posedge clk_sys_i);
            n++;
         end while (hreadyout_o !== 1'b1 && n < 20);
         if (p == 0) begin
            htrans_i <= 2'h0;
            hwdata_i <= {24'h0, wd};
         end
      end
      rd = hrdata_o;
      if (n >= 20) begin
         n_mismatch++;
         results();
      end
   endtask : bus

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      bus(1'b1, idx, d);
   endtask : wr

   task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
      bus(1'b0, idx, 8'h00);
      chk_reg(rd, exp);
   endtask : rdchk

   // flags are {over, under, window bits 5:0}
   task automatic sendchk(input logic [2:0] ch, input logic [11:0] d, input logic [7:0] exp);
      result_i <= '{valid: 1'b1, channel: ch, data: d};
      @(posedge clk_sys_i);
      result_i.valid <= 1'b0;
      @(posedge clk_sys_i);
      chk_flag({temp_over_flag_o, temp_under_flag_o, channel_range_flag_o}, exp);
   endtask : sendchk

   initial begin
      repeat (12) @(posedge clk_sys_i);
      reset_n_i <= 1'b1;
      @(posedge clk_sys_i);
      for (int c = 0; c < 5; c++)
         for (int s = 0; s < 4; s++)
            rdchk(IDX_THR_FIRST + 8'(4 * c + s), {24'h0, ch_rst[s]});
      for (int s = 0; s < 4; s++)
         rdchk(IDX_TEMP_UP_LOW + 8'(s), {24'h0, tp_rst[s]});
      rdchk(IDX_TEMP_HYST, 32'h08);
      wr(8'h60, 8'h55);
      rdchk(8'h60, 32'h0);
      for (int c = 0; c < 6; c++)
         sendchk(3'(c), (c == 5) ? 12'h000 : 12'h800, 8'h00);
      wr(8'h82, 8'h5A);
      wr(8'h83, 8'h00);
      rdchk(8'h82, 32'h5A);
      sendchk(3'h0, 12'h030, 8'h01);
      sendchk(3'h0, 12'h800, 8'h01);
      rdchk(IDX_CH_STATUS, 32'h01);
      rdchk(IDX_CH_STATUS, 32'h00);
      wr(8'h8C, 8'h00);
      sendchk(3'h3, 12'hF80, 8'h00);
      wr(8'h8D, 8'h00);
      sendchk(3'h3, 12'h000, 8'h08);
      rdchk(IDX_CH_STATUS, 32'h08);
      wr(8'h90, 8'hFF);
      wr(8'h91, 8'h07);
      sendchk(3'h4, 12'h900, 8'h10);
      sendchk(3'h5, 12'h900, 8'h10);
      rdchk(IDX_CH_STATUS, 32'h10);
      // temperature window +256 .. -256, default hysteresis 8 deg = 64 codes
      wr(IDX_TEMP_UP_LOW, 8'h00);
      wr(IDX_TEMP_UP_HIGH, 8'h01);
      wr(IDX_TEMP_LO_LOW, 8'h00);
      wr(IDX_TEMP_LO_HIGH, 8'h0F);
      sendchk(3'h5, 12'h101, 8'hA0);
      rdchk(IDX_TEMP_STATUS, 32'h02);
      rdchk(IDX_CH_STATUS, 32'h20);
      sendchk(3'h5, 12'h0D0, 8'h80);
      sendchk(3'h5, 12'h0C0, 8'h00);
      sendchk(3'h5, 12'h100, 8'h00);
      sendchk(3'h5, 12'hEFF, 8'h60);
      rdchk(IDX_TEMP_STATUS, 32'h01);
      rdchk(IDX_CH_STATUS, 32'h20);
      sendchk(3'h5, 12'hF30, 8'h40);
      sendchk(3'h5, 12'hF40, 8'h00);
      wr(IDX_TEMP_HYST, 8'h00);
      rdchk(IDX_TEMP_HYST, 32'h00);
      sendchk(3'h5, 12'h101, 8'hA0);
      sendchk(3'h5, 12'h100, 8'h20);
      reset_n_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      chk_flag({temp_over_flag_o, temp_under_flag_o, channel_range_flag_o}, 8'h00);
      reset_n_i <= 1'b1;
      @(posedge clk_sys_i);
      rdchk(IDX_TEMP_UP_HIGH, 32'h07);
      rdchk(8'h8D, 32'h0F);
      results();
   end
endmodule : tb
